//--- design/gate_fault_check.v
`timescale 1ns/1ps
`include "sleep_gate_map.vh"

// ==========================================================
// access fault detector: flags any access to an unclocked unit
module gate_fault_check
(
  input  wire        clock,
  input  wire        rstn,
  input  wire [31:0] gate_en,
  input  wire        access,
  input  wire [4:0]  access_bit,
  output reg         fault_q
);

  // one-cycle fault pulse; unimplemented gate bits read zero, so they fault too
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fault_q <= 1'b0;
    else
      fault_q <= access & ~gate_en[access_bit];
  end

endmodule // gate_fault_check

//--- design/sleep_clock_gating_reg.v
// Function
// - each implemented bit is the clock enable of one peripheral unit.
// - an access to an unclocked unit raises a bus fault.
// - gating bits reset to zero unless given another reset value.
// - this register supplies unit enables during Sleep; companions cover run and deep sleep.
// - sleep gating applies only while the automatic gating select bit is set.
// - the register resets to 0x00000040.
// - bit 25 gates the second CAN unit, reset zero.
// - bit 24 gates the first CAN unit, reset zero.
// - bit 20 gates the PWM module; access while unclocked faults.
// - bit 6 gates the standby module and resets to one.
// - bit 3 gates the watchdog; access while unclocked faults.
// - unassigned bits are read-only zero; writes to them are ignored.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "sleep_gate_map.vh"

module sleep_clock_gating_reg
#(
  parameter ADDR_W = 12
)
(
  input  wire              clock,
  input  wire              rstn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // power mode from the system controller, same clock
  input  wire              sleep_mode,
  input  wire              deep_sleep_mode,
  input  wire [31:0]       run_unit_clock_gate,
  input  wire [31:0]       deep_sleep_unit_clock_gate,
  // peripheral access monitor
  input  wire              periph_access,
  input  wire [4:0]        periph_gate_bit,
  output wire              bus_fault,
  // unit clock enables and interrupt request
  output reg               can_unit_b_gate,
  output reg               can_unit_a_gate,
  output reg               pwm_gate,
  output reg               standby_module_gate,
  output reg               watchdog_gate,
  output reg               irq
);

  // ==========================================================
  // functions

  // word index match shared by read and write decode
  function hit;
    input [ADDR_W-1:0] addr;
    input [11:0]       off;
    begin
      hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    end
  endfunction

  // byte-lane merge of write data, limited to writable bits
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [31:0] wmask;
    integer      i;
    reg   [31:0] lane;
    begin
      lane = 32'h00000000;
      for (i = 0; i < 4; i = i + 1)
        lane[i*8 +: 8] = {8{strb[i]}};
      merge = (old & ~(lane & wmask)) | (data & lane & wmask);
    end
  endfunction

  // ==========================================================
  // registers
  reg  [31:0]          scg_q;
  reg  [31:0]          ctrl_q;
  reg  [`EV_WIDTH-1:0] int_stat_q;
  reg  [`EV_WIDTH-1:0] int_en_q;
  reg  [31:0]          sleep_snap_q;
  reg  [31:0]          eff_q;
  reg                  sleep_prev_q;
  reg  [ADDR_W-1:0]    aw_addr_q;
  reg                  aw_have_q;
  reg  [31:0]          w_data_q;
  reg  [3:0]           w_strb_q;
  reg                  w_have_q;

  wire                 auto_sel;
  wire                 aw_take;
  wire                 w_take;
  wire                 wr_fire;
  wire                 ar_take;
  wire                 sleep_entry;
  wire                 fault_event;
  wire [31:0]          eff_d;
  reg  [`EV_WIDTH-1:0] int_clr_d;
  reg                  wr_ok;
  reg  [31:0]          rd_data;
  reg                  rd_ok;
  wire [`EV_WIDTH-1:0] int_set;
  wire [`EV_WIDTH-1:0] int_stat_d;

  assign auto_sel = ctrl_q[`AUTO_BIT];
  assign bus_fault = fault_event;

  // ==========================================================
  // write channel handshakes
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  // address and data are captured independently, in either order
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (w_take)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  // ready drops once a beat is held, so one write at a time
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~w_take & ~s_axi_bvalid;
    end
  end

  // write decode; clear register is write-only and pulses for one cycle
  always @*
  begin
    wr_ok     = 1'b1;
    int_clr_d = {`EV_WIDTH{1'b0}};
    if (hit(aw_addr_q, `SCG_OFF) || hit(aw_addr_q, `CTRL_OFF) ||
        hit(aw_addr_q, `INT_EN_OFF) || hit(aw_addr_q, `INT_STAT_OFF) ||
        hit(aw_addr_q, `EFF_GATE_OFF))
      wr_ok = 1'b1;
    else if (hit(aw_addr_q, `INT_CLR_OFF))
    begin
      if (wr_fire && w_strb_q[0])
        int_clr_d = w_data_q[`EV_WIDTH-1:0];
    end
    else
      wr_ok = 1'b0;
  end

  // writable registers; reserved bits never take a write
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scg_q    <= `SCG_RESET;
      ctrl_q   <= `CTRL_RESET;
      int_en_q <= {`EV_WIDTH{1'b0}};
    end
    else if (wr_fire)
    begin
      if (hit(aw_addr_q, `SCG_OFF))
        scg_q <= merge(scg_q, w_data_q, w_strb_q, `SCG_WMASK);
      if (hit(aw_addr_q, `CTRL_OFF))
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q, `CTRL_WMASK);
      if (hit(aw_addr_q, `INT_EN_OFF) && w_strb_q[0])
        int_en_q <= w_data_q[`EV_WIDTH-1:0];
    end
  end

  // write response; unmapped offsets answer slverr
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // read channel
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // read mux; reserved bits read as zero since they are never stored
  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (hit(s_axi_araddr, `SCG_OFF))
      rd_data = scg_q & `SCG_WMASK;
    else if (hit(s_axi_araddr, `CTRL_OFF))
      rd_data = ctrl_q & `CTRL_WMASK;
    else if (hit(s_axi_araddr, `INT_STAT_OFF))
      rd_data[`EV_WIDTH-1:0] = int_stat_q;
    else if (hit(s_axi_araddr, `INT_EN_OFF))
      rd_data[`EV_WIDTH-1:0] = int_en_q;
    else if (hit(s_axi_araddr, `INT_CLR_OFF))
      rd_data = 32'h00000000;
    else if (hit(s_axi_araddr, `EFF_GATE_OFF))
      rd_data = eff_q;
    else
      rd_ok = 1'b0;
  end

  // one read at a time: arready stays low while data waits
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // mode selection of unit enables
  assign sleep_entry = sleep_mode & ~sleep_prev_q;

  // snapshot at sleep entry so mid-sleep writes wait for the next entry
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sleep_prev_q <= 1'b0;
      sleep_snap_q <= `SCG_RESET;
    end
    else
    begin
      sleep_prev_q <= sleep_mode;
      if (sleep_entry)
        sleep_snap_q <= scg_q & `SCG_WMASK;
    end
  end

  // deep sleep outranks sleep; without auto select run enables stay in force
  assign eff_d = (deep_sleep_mode && auto_sel) ? deep_sleep_unit_clock_gate :
                 (sleep_mode && auto_sel)      ? sleep_snap_q :
                                                 run_unit_clock_gate;

  // unit enables leave from flip-flops to keep clock gate cells glitch free
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      eff_q               <= 32'h00000000;
      can_unit_b_gate     <= 1'b0;
      can_unit_a_gate     <= 1'b0;
      pwm_gate            <= 1'b0;
      standby_module_gate <= 1'b0;
      watchdog_gate       <= 1'b0;
    end
    else
    begin
      eff_q               <= eff_d & `SCG_WMASK;
      can_unit_b_gate     <= eff_d[`CAN_B_BIT];
      can_unit_a_gate     <= eff_d[`CAN_A_BIT];
      pwm_gate            <= eff_d[`PWM_BIT];
      standby_module_gate <= eff_d[`STANDBY_BIT];
      watchdog_gate       <= eff_d[`WDOG_BIT];
    end
  end

  // ==========================================================
  // access fault detection against the enables in force
  gate_fault_check u_fault
  (
    .clock      (clock),
    .rstn       (rstn),
    .gate_en    (eff_q),
    .access     (periph_access),
    .access_bit (periph_gate_bit),
    .fault_q    (fault_event)
  );

  // ==========================================================
  // interrupt status: set wins over a clear in the same cycle
  assign int_set    = {sleep_entry & auto_sel, fault_event};
  assign int_stat_d = (int_stat_q & ~int_clr_d) | int_set;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      int_stat_q <= {`EV_WIDTH{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      irq        <= |(int_stat_d & int_en_q);
    end
  end

endmodule // sleep_clock_gating_reg

//--- design/sleep_gate_map.vh
`ifndef SLEEP_GATE_MAP_VH
`define SLEEP_GATE_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define SCG_OFF        12'h110
`define CTRL_OFF       12'h130
`define INT_STAT_OFF   12'h134
`define INT_CLR_OFF    12'h138
`define INT_EN_OFF     12'h13c
`define EFF_GATE_OFF   12'h140

// ==========================================================
// gate bit positions
`define CAN_B_BIT      25
`define CAN_A_BIT      24
`define PWM_BIT        20
`define STANDBY_BIT    6
`define WDOG_BIT       3

// ==========================================================
// reset values and writable masks
`define SCG_RESET      32'h00000040
`define SCG_WMASK      32'h03100048
`define CTRL_RESET     32'h00000000
`define AUTO_BIT       0
`define CTRL_WMASK     32'h00000001

// ==========================================================
// event bits of the status, clear and enable registers
`define EV_FAULT       0
`define EV_SLEEP       1
`define EV_WIDTH       2

// ==========================================================
// bus response codes
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

//--- tb/gate_rules_checker.sv
`timescale 1ns/1ps

module gate_rules_checker
(
  input wire        clock,
  input wire        rstn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        sleep_mode,
  input wire        deep_sleep_mode,
  input wire [31:0] run_unit_clock_gate,
  input wire        periph_access,
  input wire [4:0]  periph_gate_bit,
  input wire        bus_fault,
  input wire        can_unit_b_gate,
  input wire        can_unit_a_gate,
  input wire        pwm_gate,
  input wire        standby_module_gate,
  input wire        watchdog_gate
);
  // ==========================================================
  // bus and gating relations
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  // outside sleep the run enables pass through one edge late
  a_run_gates: assert property (!sleep_mode && !deep_sleep_mode
    |=> {can_unit_b_gate, can_unit_a_gate, pwm_gate, standby_module_gate, watchdog_gate} ==
    $past({run_unit_clock_gate[25], run_unit_clock_gate[24], run_unit_clock_gate[20],
    run_unit_clock_gate[6], run_unit_clock_gate[3]}))
    else $error("unit enable differs from run enable");
  a_wdog_fault: assert property (periph_access && periph_gate_bit == 5'h03
    |=> bus_fault == !$past(watchdog_gate)) else $error("watchdog fault wrong");
  a_pwm_fault: assert property (periph_access && periph_gate_bit == 5'h14
    |=> bus_fault == !$past(pwm_gate)) else $error("pwm fault wrong");
  a_fault_cause: assert property (!periph_access |=> !bus_fault)
    else $error("fault without access");

  c_fault: cover property (bus_fault);
  c_sleep_pwm: cover property (sleep_mode && pwm_gate);
  c_deep: cover property (deep_sleep_mode && standby_module_gate);
endmodule // gate_rules_checker

bind sleep_clock_gating_reg gate_rules_checker u_chk (.clock, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleep_mode,
  .deep_sleep_mode, .run_unit_clock_gate, .periph_access, .periph_gate_bit, .bus_fault,
  .can_unit_b_gate, .can_unit_a_gate, .pwm_gate, .standby_module_gate, .watchdog_gate);

//--- tb/sleep_clock_gating_reg_tb_top.sv
`timescale 1ns/1ps
`include "sleep_gate_map.vh"

module sleep_clock_gating_reg_tb_top;
  logic        clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, sleep_mode, deep_sleep_mode, periph_access;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, run_unit_clock_gate, deep_sleep_unit_clock_gate, d;
  logic [4:0]  periph_gate_bit;
  logic [1:0]  resp;
  logic        f;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_fault;
  wire         can_unit_b_gate, can_unit_a_gate, pwm_gate, standby_module_gate, watchdog_gate, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          n_fail, compares, cyc;
  wire [4:0]   gates = {can_unit_b_gate, can_unit_a_gate, pwm_gate, standby_module_gate,
                        watchdog_gate};

  sleep_clock_gating_reg DUT (.clock, .rstn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode,
    .deep_sleep_mode, .run_unit_clock_gate, .deep_sleep_unit_clock_gate, .periph_access,
    .periph_gate_bit, .bus_fault, .can_unit_b_gate, .can_unit_a_gate, .pwm_gate,
    .standby_module_gate, .watchdog_gate, .irq);

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [4:0] pick(input logic [31:0] v);
    return {v[25], v[24], v[20], v[6], v[3]};
  endfunction
  // address and data go out together, each dropped once taken; bready and rready
  // stay high between calls so back-to-back calls never drive them twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  // one access pulse; the fault shows in the following cycle
  task automatic poke(input logic [4:0] b);
    periph_access <= 1'b1;
    periph_gate_bit <= b;
    @(posedge clock);
    periph_access <= 1'b0;
    @(posedge clock);
    f = bus_fault;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_bits();
    int bits[5] = '{25, 24, 20, 6, 3};
    rd(`SCG_OFF);
    chk(d, 32'h00000040);
    wr(`SCG_OFF, d | 32'h00000008);
    rd(`SCG_OFF);
    chk(d, 32'h00000048);
    foreach (bits[i])
    begin
      wr(`SCG_OFF, 32'h1 << bits[i]);
      rd(`SCG_OFF);
      chk(d, 32'h1 << bits[i]);
    end
    wr(`SCG_OFF, 32'hfcefffb7);
    rd(`SCG_OFF);
    chk(d, 32'h00000000);
    wr(`SCG_OFF, 32'hffffffff);
    rd(`SCG_OFF);
    chk(d, 32'h03100048);
    wr(12'h200, 32'h00000000);
    chk(resp, 2'b10);
    rd(12'h200);
    chk(resp, 2'b10);
  endtask
  task automatic t_modes();
    run_unit_clock_gate <= 32'h03100048;
    settle();
    chk(gates, 5'h1f);
    sleep_mode <= 1'b1;
    run_unit_clock_gate <= 32'h00000008;
    settle();
    chk(gates, 5'h01);
    sleep_mode <= 1'b0;
    wr(`CTRL_OFF, 32'h1);
    wr(`SCG_OFF, 32'h00100008);
    sleep_mode <= 1'b1;
    settle();
    chk(gates, pick(32'h00100008));
    wr(`SCG_OFF, 32'h02000000);
    settle();
    chk(gates, pick(32'h00100008));
    sleep_mode <= 1'b0;
    settle();
    sleep_mode <= 1'b1;
    settle();
    chk(gates, pick(32'h02000000));
    deep_sleep_mode <= 1'b1;
    settle();
    chk(gates, pick(32'h00000040));
    rd(`EFF_GATE_OFF);
    chk(d, 32'h00000040);
    deep_sleep_mode <= 1'b0;
    sleep_mode <= 1'b0;
    wr(`CTRL_OFF, 32'h0);
    settle();
  endtask
  // fault is sticky: masked first, then unmasked, then cleared
  task automatic t_fault();
    rd(`INT_STAT_OFF);
    chk(d, 32'h2);
    wr(`INT_CLR_OFF, 32'h3);
    poke(5'h14);
    chk(f, 1'b1);
    poke(5'h03);
    chk(f, 1'b0);
    settle();
    chk(irq, 1'b0);
    rd(`INT_STAT_OFF);
    chk(d, 32'h1);
    wr(`INT_EN_OFF, 32'h1);
    settle();
    chk(irq, 1'b1);
    wr(`INT_CLR_OFF, 32'h1);
    settle();
    chk(irq, 1'b0);
  endtask
  // mid-run reset: outputs drop at once, the gating register comes back at its reset value
  task automatic t_reset();
    poke(5'h14);
    settle();
    chk(irq, 1'b1);
    rstn <= 1'b0;
    @(posedge clock);
    chk(gates, 5'h00);
    chk(irq, 1'b0);
    @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(`SCG_OFF);
    chk(d, 32'h00000040);
    settle();
    chk(gates, pick(run_unit_clock_gate));
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sleep_mode, deep_sleep_mode, periph_access, periph_gate_bit} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    run_unit_clock_gate = 32'h0;
    deep_sleep_unit_clock_gate = 32'h00000040;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_bits();
    t_modes();
    t_fault();
    t_reset();
    stop_test();
  end
endmodule // sleep_clock_gating_reg_tb_top
